// >>> vqa_map.svh
// constant map for the available-ring engine
`ifndef VQA_MAP_SVH
`define VQA_MAP_SVH
`define VQA_IDX_W        16
`define VQA_IDX_ONE      16'h0001
`define VQA_IDX_ZERO     16'h0000
`define VQA_MAX_QSIZE    17'h0_8000
`define VQA_DEVID_OFFSET 16'h0FFF
`define VQA_REV_LEGACY   8'h00
`define VQA_REV_MODERN   8'h01
`define VQA_SUBSYS_MIN   16'h0040
`define VQA_WORD_ZERO    32'h0000_0000
`define VQA_FLAG_ON      1'b1
`define VQA_FLAG_OFF     1'b0
`endif

// >>> vqa_pkg.sv
// types shared by the available-ring engine
package vqa_pkg;
  typedef struct packed {
    logic [15:0] vendor_id;
    logic [15:0] device_id;
    logic [7:0]  revision_id;
    logic [15:0] subsys_vendor_id;
    logic [15:0] subsys_device_id;
  } vqa_ident_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] slot;
    logic [15:0] idx;
  } vqa_fetch_t;

  typedef enum logic [1:0] {
    VQA_IDLE  = 2'b00,
    VQA_FETCH = 2'b01,
    VQA_WAIT  = 2'b10
  } vqa_state_t;
endpackage

// >>> vqa_ident.sv
// pci identification values and little-endian field packing
`timescale 1ns/1ps
`include "vqa_map.svh"
module vqa_ident #(
  parameter logic [15:0] VENDOR_ID    = 16'h5A5A, // arbitrary value
  parameter logic [15:0] SUBSYS_VENDOR = 16'h5A5A, // arbitrary value
  parameter logic [15:0] TYPE_NUM     = 16'h0001,
  parameter bit          LEGACY       = 1'b0
) (
  // identity
  output vqa_pkg::vqa_ident_t ident_out,
  // little-endian image of the id words
  output logic [31:0]         id_word_le_out
);
  import vqa_pkg::*;
  // device id is type number plus fixed offset
  assign ident_out.vendor_id        = VENDOR_ID;
  assign ident_out.device_id        = TYPE_NUM + `VQA_DEVID_OFFSET;
  assign ident_out.revision_id      = LEGACY ? `VQA_REV_LEGACY : `VQA_REV_MODERN;
  assign ident_out.subsys_vendor_id = SUBSYS_VENDOR;
  assign ident_out.subsys_device_id = LEGACY ? TYPE_NUM :
    ((TYPE_NUM < `VQA_SUBSYS_MIN) ? `VQA_SUBSYS_MIN + TYPE_NUM : TYPE_NUM);
  // byte 0 is the low byte of vendor id
  assign id_word_le_out = {ident_out.device_id, ident_out.vendor_id};
endmodule

// >>> vqa_idx_cmp.sv
// modulo-65536 distance between two running indices
`timescale 1ns/1ps
module vqa_idx_cmp #(
  parameter int W = 16
) (
  // operands
  input  wire logic [W-1:0] pub_in,
  input  wire logic [W-1:0] seen_in,
  // results
  output logic [W-1:0]      diff_out,
  output logic              pending_out
);
  // subtraction wraps naturally in W bits
  assign diff_out    = W'(pub_in - seen_in);
  assign pending_out = |diff_out;
endmodule

// >>> vqa_avail.sv
// available-ring engine: index tracking, fetch issue, interrupts, identity
`timescale 1ns/1ps
`include "vqa_map.svh"
module vqa_avail #(
  parameter int          QSIZE_LOG2    = 8,
  parameter logic [15:0] VENDOR_ID     = 16'h5A5A, // arbitrary value
  parameter logic [15:0] SUBSYS_VENDOR = 16'h5A5A, // arbitrary value
  parameter logic [15:0] TYPE_NUM      = 16'h0001,
  parameter bit          LEGACY        = 1'b0
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  // driver status and queue setup
  input  wire logic              driver_live_in,
  input  wire logic              device_reset_in,
  input  wire logic              queue_enable_in,
  input  wire logic              event_idx_in,
  // ring state read from host memory
  input  wire logic [15:0]       avail_idx_in,
  input  wire logic              avail_idx_valid_in,
  input  wire logic              avail_no_irq_in,
  input  wire logic [15:0]       used_event_in,
  input  wire logic              notify_in,
  // device-side consumer
  input  wire logic              poll_mode_in,
  input  wire logic              fetch_ready_in,
  input  wire logic              used_done_in,
  input  wire logic [15:0]       used_idx_in,
  input  wire logic              cfg_changed_in,
  input  wire logic              wants_reinit_in,
  // fetch requests
  output vqa_pkg::vqa_fetch_t    fetch_out,
  output logic [15:0]            pending_count_out,
  // used-ring suppression word
  output logic                   used_no_notify_out,
  output logic [15:0]            avail_event_out,
  // interrupts to driver
  output logic                   used_irq_out,
  output logic                   cfg_irq_out,
  // status
  output logic                   queue_live_out,
  output logic                   device_wants_reinit_bit_out,
  output logic                   spurious_notify_out,
  output vqa_pkg::vqa_ident_t    ident_out,
  output logic [31:0]            id_word_le_out
);
  import vqa_pkg::*;

  // ------------------------------------------------------------
  // local signals
  // ------------------------------------------------------------
  localparam logic [15:0] SLOT_MASK = 16'((`VQA_MAX_QSIZE >> (15 - QSIZE_LOG2)) - 17'h1);
  logic [15:0]  pub_idx;
  logic [15:0]  seen_idx;
  logic [15:0]  last_used;
  logic [15:0]  diff;
  logic         pending;
  vqa_state_t   state;
  vqa_state_t   next_state;
  vqa_ident_t   ident_w;
  logic [31:0]  id_word_w;
  logic         used_fire;

  // ------------------------------------------------------------
  // sub-blocks
  // ------------------------------------------------------------
  vqa_idx_cmp #(.W(`VQA_IDX_W)) u_cmp (
    .pub_in      (pub_idx),
    .seen_in     (seen_idx),
    .diff_out    (diff),
    .pending_out (pending)
  );

  vqa_ident #(
    .VENDOR_ID     (VENDOR_ID),
    .SUBSYS_VENDOR (SUBSYS_VENDOR),
    .TYPE_NUM      (TYPE_NUM),
    .LEGACY        (LEGACY)
  ) u_ident (
    .ident_out      (ident_w),
    .id_word_le_out (id_word_w)
  );

  // ------------------------------------------------------------
  // liveness
  // ------------------------------------------------------------
  // queue goes live on driver-live with queue enable and dies on device reset
  // live lags the driver status bits by one cycle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      queue_live_out <= `VQA_FLAG_OFF;
    end else if (device_reset_in) begin
      queue_live_out <= `VQA_FLAG_OFF;
    end else begin
      queue_live_out <= driver_live_in & queue_enable_in;
    end
  end

  // ------------------------------------------------------------
  // published index capture
  // ------------------------------------------------------------
  // only an index at or ahead of seen is accepted; a live queue never rewinds below seen
  // a jump past the queue size would alias ring slots, so it is ignored
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pub_idx <= `VQA_IDX_ZERO;
    end else if (device_reset_in || !queue_live_out) begin
      pub_idx <= `VQA_IDX_ZERO;
    end else if (avail_idx_valid_in &&
                 (16'(avail_idx_in - seen_idx) <= 16'(SLOT_MASK + `VQA_IDX_ONE))) begin
      pub_idx <= avail_idx_in;
    end
  end

  // ------------------------------------------------------------
  // fetch state machine
  // ------------------------------------------------------------
  // issue one slot per accepted request from seen up to published
  always_comb begin
    next_state = state;
    case (state)
      VQA_IDLE: begin
        if (queue_live_out && pending) begin
          next_state = VQA_FETCH;
        end
      end
      VQA_FETCH: begin
        if (!queue_live_out) begin
          next_state = VQA_IDLE;
        end else if (fetch_ready_in) begin
          next_state = VQA_WAIT;
        end
      end
      VQA_WAIT: begin
        next_state = VQA_IDLE;
      end
      default: begin
        next_state = VQA_IDLE;
      end
    endcase
  end

  // state register; a device reset drops any half-issued fetch
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= VQA_IDLE;
    end else if (device_reset_in) begin
      state <= VQA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // last seen index advances with every accepted fetch
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seen_idx <= `VQA_IDX_ZERO;
    end else if (device_reset_in || !queue_live_out) begin
      seen_idx <= `VQA_IDX_ZERO;
    end else if (state == VQA_FETCH && fetch_ready_in) begin
      seen_idx <= 16'(seen_idx + `VQA_IDX_ONE);
    end
  end

  // fetch request presented from a register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fetch_out <= '0;
    end else if (device_reset_in || next_state != VQA_FETCH) begin
      fetch_out <= '0;
    end else begin
      fetch_out.valid <= `VQA_FLAG_ON;
      fetch_out.slot  <= (state == VQA_FETCH && fetch_ready_in) ?
                         (16'(seen_idx + `VQA_IDX_ONE) & SLOT_MASK) :
                         (seen_idx & SLOT_MASK);
      fetch_out.idx   <= (state == VQA_FETCH && fetch_ready_in) ?
                         16'(seen_idx + `VQA_IDX_ONE) : seen_idx;
    end
  end

  // outstanding entries, wrap-safe
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pending_count_out <= `VQA_IDX_ZERO;
    end else begin
      pending_count_out <= diff;
    end
  end

  // ------------------------------------------------------------
  // notification suppression and spurious notifications
  // ------------------------------------------------------------
  // advise the driver while polling; event index uses the threshold
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      used_no_notify_out <= `VQA_FLAG_OFF;
      avail_event_out    <= `VQA_IDX_ZERO;
    end else begin
      used_no_notify_out <= poll_mode_in & ~event_idx_in;
      avail_event_out    <= poll_mode_in ? 16'(pub_idx - `VQA_IDX_ONE) : pub_idx;
    end
  end

  // a notification with nothing new is only flagged, never acted on
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      spurious_notify_out <= `VQA_FLAG_OFF;
    end else begin
      spurious_notify_out <= notify_in & ~pending &
                             ~(avail_idx_valid_in && avail_idx_in != pub_idx);
    end
  end

  // ------------------------------------------------------------
  // used-buffer interrupt
  // ------------------------------------------------------------
  // event index: fire when used index steps past the driver threshold
  always_comb begin
    if (event_idx_in) begin
      used_fire = 16'(used_idx_in - used_event_in - `VQA_IDX_ONE) <
                  16'(used_idx_in - last_used);
    end else begin
      used_fire = ~avail_no_irq_in;
    end
  end

  // interrupt pulse and the used index last reported to the driver
  // last_used must follow every return, or the threshold test goes stale
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      last_used    <= `VQA_IDX_ZERO;
      used_irq_out <= `VQA_FLAG_OFF;
    end else if (device_reset_in) begin
      last_used    <= `VQA_IDX_ZERO;
      used_irq_out <= `VQA_FLAG_OFF;
    end else begin
      used_irq_out <= used_done_in & queue_live_out & used_fire;
      if (used_done_in) begin
        last_used <= used_idx_in;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration-change interrupt and reinit status
  // ------------------------------------------------------------
  // the status bit is sticky until device reset; setting it pulses the interrupt
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      device_wants_reinit_bit_out <= `VQA_FLAG_OFF;
      cfg_irq_out                 <= `VQA_FLAG_OFF;
    end else begin
      if (wants_reinit_in) begin
        device_wants_reinit_bit_out <= `VQA_FLAG_ON; // set wins over reset clear
      end else if (device_reset_in) begin
        device_wants_reinit_bit_out <= `VQA_FLAG_OFF;
      end
      cfg_irq_out <= cfg_changed_in |
                     (wants_reinit_in & ~device_wants_reinit_bit_out);
    end
  end

  // ------------------------------------------------------------
  // identity, registered
  // ------------------------------------------------------------
  // identity is constant; registered so every output comes from a flop
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ident_out      <= '0;
      id_word_le_out <= `VQA_WORD_ZERO;
    end else begin
      ident_out      <= ident_w;
      id_word_le_out <= id_word_w;
    end
  end
endmodule

// >>> vqa_avail_sva.sv
// concurrent checks on the ports of the available-ring engine
`timescale 1ns/1ps
`include "vqa_map.svh"
module vqa_avail_sva #(
  parameter int          QSIZE_LOG2 = 8,
  parameter logic [15:0] VENDOR_ID  = 16'h5A5A, // arbitrary value
  parameter logic [15:0] TYPE_NUM   = 16'h0001,
  parameter bit          LEGACY     = 1'b0
) (
  // clock, reset and driver inputs
  input wire logic                clk_in,
  input wire logic                reset_n_in,
  input wire logic                driver_live_in,
  input wire logic                device_reset_in,
  input wire logic                queue_enable_in,
  input wire logic                event_idx_in,
  input wire logic                avail_no_irq_in,
  input wire logic                fetch_ready_in,
  input wire logic                used_done_in,
  input wire logic                cfg_changed_in,
  input wire logic                wants_reinit_in,
  // design outputs
  input wire vqa_pkg::vqa_fetch_t fetch_out,
  input wire logic                used_irq_out,
  input wire logic                cfg_irq_out,
  input wire logic                queue_live_out,
  input wire logic                device_wants_reinit_bit_out,
  input wire vqa_pkg::vqa_ident_t ident_out,
  input wire logic [31:0]         id_word_le_out
);
  import vqa_pkg::*;
  localparam logic [15:0] MASK = 16'((1 << QSIZE_LOG2) - 1);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ----------------------------------------------------------------
  // queue liveness and fetch issue
  // ----------------------------------------------------------------
  a_live_follow: assert property (
    !device_reset_in && driver_live_in && queue_enable_in |=> queue_live_out)
    else $error("queue not live after driver went live");
  a_dead_quiet: assert property (
    !queue_live_out && $past(queue_live_out == 1'b0) |-> !fetch_out.valid)
    else $error("fetch issued on a queue that is not live");
  a_slot_mod: assert property (
    fetch_out.valid |-> fetch_out.slot == (fetch_out.idx & MASK))
    else $error("fetch slot is not index modulo queue size");
  a_fetch_hold: assert property (
    fetch_out.valid && !fetch_ready_in && queue_live_out && !device_reset_in
      |=> fetch_out.valid && $stable(fetch_out.idx))
    else $error("fetch request dropped before acceptance");
  a_fetch_gap: assert property (
    fetch_out.valid && fetch_ready_in |=> !fetch_out.valid)
    else $error("fetch request stayed after acceptance");
  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  a_used_irq: assert property (
    used_done_in && queue_live_out && !event_idx_in && !avail_no_irq_in |=> used_irq_out)
    else $error("no interrupt after buffers returned");
  a_irq_masked: assert property (
    used_done_in && !event_idx_in && avail_no_irq_in |=> !used_irq_out)
    else $error("interrupt raised while driver suppresses it");
  a_cfg_irq: assert property (
    cfg_changed_in |=> cfg_irq_out)
    else $error("no interrupt on configuration change");
  a_reinit_irq: assert property (
    wants_reinit_in && !device_wants_reinit_bit_out |=> cfg_irq_out && device_wants_reinit_bit_out)
    else $error("reinit bit set without configuration interrupt");
  // ----------------------------------------------------------------
  // identification
  // ----------------------------------------------------------------
  a_ident_ids: assert property (
    $past(reset_n_in) |-> ident_out.vendor_id == VENDOR_ID
      && ident_out.device_id == TYPE_NUM + `VQA_DEVID_OFFSET)
    else $error("vendor or device identifier wrong");
  a_ident_rev: assert property (
    !LEGACY && $past(reset_n_in) |-> ident_out.revision_id >= 8'h01
      && ident_out.subsys_device_id >= 16'h0040)
    else $error("revision or subsystem identifier too low");
  a_le_word: assert property (
    $past(reset_n_in) |-> id_word_le_out == {ident_out.device_id, ident_out.vendor_id})
    else $error("identifier word not little-endian");
endmodule
bind vqa_avail vqa_avail_sva #(.QSIZE_LOG2(QSIZE_LOG2), .VENDOR_ID(VENDOR_ID),
  .TYPE_NUM(TYPE_NUM), .LEGACY(LEGACY)) u_sva (.clk_in, .reset_n_in, .driver_live_in,
  .device_reset_in, .queue_enable_in, .event_idx_in, .avail_no_irq_in, .fetch_ready_in,
  .used_done_in, .cfg_changed_in, .wants_reinit_in, .fetch_out, .used_irq_out, .cfg_irq_out,
  .queue_live_out, .device_wants_reinit_bit_out, .ident_out, .id_word_le_out);

// >>> vqa_drv_model.sv
// host driver model: publishes ring entries and rings the doorbell
`timescale 1ns/1ps
module vqa_drv_model (
  // clock and suppression word read back
  input  wire logic  clk_in,
  input  wire logic  no_notify_in,
  // published index and doorbell
  output logic [15:0] avail_idx_out,
  output logic        avail_idx_valid_out,
  output logic        notify_out
);
  initial begin
    avail_idx_out = 16'h0000;
    avail_idx_valid_out = 1'b0;
    notify_out = 1'b0;
  end
  // entries and descriptors are in memory first, then one index bump for the batch
  task automatic publish(input logic [15:0] added);
    @(posedge clk_in);
    avail_idx_out <= avail_idx_out + added;
    avail_idx_valid_out <= 1'b1;
    @(posedge clk_in);
    avail_idx_valid_out <= 1'b0;
    // suppression word is read only after the index is out
    if (!no_notify_in) begin
      notify_out <= 1'b1;
      @(posedge clk_in);
      notify_out <= 1'b0;
    end
  endtask
  // after a device reset the ring starts over from zero
  task automatic restart();
    @(posedge clk_in);
    avail_idx_out <= 16'h0000;
  endtask
endmodule

// >>> testbench.sv
// self-checking bench for the available-ring engine
`timescale 1ns/1ps
module testbench;
  import vqa_pkg::*;
  typedef struct {logic [15:0] add; int fetches;} vqa_row_t;
  logic clk_in, reset_n_in, live_in, dev_rst, q_en, ev_idx, no_irq, poke, poll, ready;
  logic [2:0] ev;
  logic [15:0] used_event, aidx, seen, pend, aev;
  logic avalid, ntf, no_ntf, uirq, cirq, live, wbit, spur;
  logic [31:0] id_word;
  vqa_fetch_t fetch;
  vqa_ident_t ident;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  vqa_row_t rows[4] = '{'{16'h0001, 1}, '{16'h0003, 3}, '{16'h0004, 4}, '{16'h0002, 2}};
  vqa_drv_model drv (.clk_in(clk_in), .no_notify_in(no_ntf), .avail_idx_out(aidx),
    .avail_idx_valid_out(avalid), .notify_out(ntf));
  vqa_avail #(.QSIZE_LOG2(2), .VENDOR_ID(16'h3C3C), .TYPE_NUM(16'h0002)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .driver_live_in(live_in), .device_reset_in(dev_rst), .queue_enable_in(q_en),
    .event_idx_in(ev_idx), .avail_idx_in(aidx), .avail_idx_valid_in(avalid),
    .avail_no_irq_in(no_irq), .used_event_in(used_event), .notify_in(ntf | poke),
    .poll_mode_in(poll), .fetch_ready_in(ready), .used_done_in(ev[2]), .used_idx_in(seen),
    .cfg_changed_in(ev[1]), .wants_reinit_in(ev[0]), .fetch_out(fetch),
    .pending_count_out(pend), .used_no_notify_out(no_ntf), .avail_event_out(aev),
    .used_irq_out(uirq), .cfg_irq_out(cirq), .queue_live_out(live),
    .device_wants_reinit_bit_out(wbit), .spurious_notify_out(spur), .ident_out(ident),
    .id_word_le_out(id_word));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // hang guard
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      conclude();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // accept one fetch request, optionally stalling first
  task automatic take(input bit stall);
    int w = 0;
    #1;
    while (fetch.valid !== 1'b1 && w < 20) begin
      step(1);
      w++;
    end
    chk("fetch_valid", 32'h1, {31'h0, fetch.valid});
    chk("fetch_idx", {16'h0, seen}, {16'h0, fetch.idx});
    chk("fetch_slot", {16'h0, seen & 16'h0003}, {16'h0, fetch.slot});
    if (stall) step(2);
    @(posedge clk_in);
    ready <= 1'b1;
    @(posedge clk_in);
    ready <= 1'b0;
    seen = seen + 16'h0001;
    #1;
  endtask
  // pulse events and look at the interrupt outputs one edge later
  task automatic fire(input logic [2:0] v, input logic [2:0] want);
    @(posedge clk_in);
    ev <= v;
    @(posedge clk_in);
    ev <= 3'b000;
    #1;
    chk("irqs", {29'h0, want}, {29'h0, uirq, cirq, wbit});
  endtask
  task automatic conclude();
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    {reset_n_in, live_in, dev_rst, q_en, ev_idx, no_irq, poke, poll, ready} = '0;
    ev = 3'b000;
    used_event = 16'h0000;
    seen = 16'h0000;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    live_in <= 1'b1;
    q_en <= 1'b1;
    step(3);
    chk("live", 32'h1, {31'h0, live});
    chk("id_word", 32'h1001_3C3C, id_word);
    chk("rev_ok", 32'h1, {31'h0, ident.revision_id >= 8'h01});
    chk("subsys_ok", 32'h1, {31'h0, ident.subsys_device_id >= 16'h0040});
    foreach (rows[r]) begin
      drv.publish(rows[r].add);
      for (int k = 0; k < rows[r].fetches; k++) take(k == 0);
      step(4);
      chk("pending", 32'h0, {16'h0, pend});
      chk("idle", 32'h0, {31'h0, fetch.valid});
    end
    // index jump beyond the queue size is refused
    drv.publish(16'h0005);
    step(6);
    chk("refused", 32'h0, {15'h0, fetch.valid, pend});
    // device reset kills the queue, then it restarts at zero
    @(posedge clk_in);
    dev_rst <= 1'b1;
    live_in <= 1'b0;
    drv.restart();
    step(2);
    chk("dead", 32'h0, {31'h0, live});
    @(posedge clk_in);
    dev_rst <= 1'b0;
    live_in <= 1'b1;
    step(3);
    seen = 16'h0000;
    drv.publish(16'h0001);
    take(1'b0);
    // doorbell with nothing new
    @(posedge clk_in);
    poke <= 1'b1;
    @(posedge clk_in);
    poke <= 1'b0;
    #1;
    chk("spurious", 32'h1, {31'h0, spur});
    step(3);
    chk("no_fetch", 32'h0, {31'h0, fetch.valid});
    // polling asks the driver to hold off
    @(posedge clk_in);
    poll <= 1'b1;
    step(3);
    chk("no_notify", 32'h1, {31'h0, no_ntf});
    chk("avail_event", {16'h0, aidx - 16'h0001}, {16'h0, aev});
    @(posedge clk_in);
    ev_idx <= 1'b1;
    step(3);
    chk("flags_zero", 32'h0, {31'h0, no_ntf});
    @(posedge clk_in);
    ev_idx <= 1'b0;
    poll <= 1'b0;
    fire(3'b100, 3'b100);
    @(posedge clk_in);
    no_irq <= 1'b1;
    fire(3'b100, 3'b000);
    fire(3'b010, 3'b010);
    fire(3'b001, 3'b011);
    // event index: interrupt only once the used index steps past the threshold
    seen = 16'h0003;
    @(posedge clk_in);
    ev_idx <= 1'b1;
    used_event <= 16'h0004;
    fire(3'b100, 3'b001);
    seen = 16'h0006;
    fire(3'b100, 3'b101);
    step(2);
    conclude();
  end
endmodule
